// [src/pml_pkg.sv]
// Purpose: Shared constants and types of the power monitor limit/alert block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Results are two's complement; power is unsigned 24 bits
package pml_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] PML_OFS_CONFIG     = 8'h00;
    localparam logic [7:0] PML_OFS_ADC_CONFIG = 8'h04;
    localparam logic [7:0] PML_OFS_SHUNT_CAL  = 8'h08;
    localparam logic [7:0] PML_OFS_SHUNT_RES  = 8'h0C;
    localparam logic [7:0] PML_OFS_BUS_RES    = 8'h10;
    localparam logic [7:0] PML_OFS_TEMP_RES   = 8'h14;
    localparam logic [7:0] PML_OFS_CURRENT    = 8'h18;
    localparam logic [7:0] PML_OFS_POWER      = 8'h1C;
    localparam logic [7:0] PML_OFS_SHUNT_LIM  = 8'h20;
    localparam logic [7:0] PML_OFS_BUS_LIM    = 8'h24;
    localparam logic [7:0] PML_OFS_POWER_LIM  = 8'h28;
    localparam logic [7:0] PML_OFS_IRQ_STS    = 8'h2C;
    localparam logic [7:0] PML_OFS_IRQ_MASK   = 8'h30;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int PML_CFG_RANGE_BIT = 0;   // 1 selects the narrow shunt range
    localparam int PML_CFG_AVGAL_BIT = 1;   // averaged_alert_select
    localparam int PML_CFG_CNVAL_BIT = 2;   // alert follows conversion ready
    localparam int PML_ADC_AVG_LSB   = 3;   // two-bit averaging select
    localparam int PML_STS_SHUNT     = 0;
    localparam int PML_STS_BUS       = 1;
    localparam int PML_STS_POWER     = 2;
    localparam int PML_STS_CNVRDY    = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and arithmetic constants
    localparam logic [2:0]  PML_RST_CONFIG  = 3'h0;        // Wide range, raw alerts
    localparam logic [2:0]  PML_RST_ADC_EN  = 3'h7;        // Shunt, bus, temp continuous
    localparam logic [1:0]  PML_RST_ADC_AVG = 2'h0;
    localparam logic [14:0] PML_RST_CAL     = 15'h0000;
    localparam logic [15:0] PML_RST_SLIM    = 16'h7FFF;
    localparam logic [15:0] PML_RST_BLIM    = 16'h7FFF;
    localparam logic [15:0] PML_RST_PLIM    = 16'hFFFF;
    localparam int          PML_CUR_SHIFT   = 11;          // Current = shunt * cal / 2^11
    localparam int          PML_PWR_SHIFT   = 6;           // 3.125 mV / 0.2 = 1/64
    localparam int          PML_PLIM_SHIFT  = 8;           // One limit LSB = 256 power LSBs
    localparam int          PML_NARROW_SHR  = 2;           // 1.25 uV codes to 5 uV codes
    localparam logic [1:0]  PML_CH_SHUNT    = 2'h0;
    localparam logic [1:0]  PML_CH_BUS      = 2'h1;
    localparam logic [1:0]  PML_CH_TEMP     = 2'h2;
    localparam int          PML_ACC_W       = 22;

    ////////////////////////////////////////////////////////////////////////////
    // One conversion word from the front end
    typedef struct packed {
        logic [1:0]  chan;
        logic [15:0] data;
    } pml_sample_t;

    // Derived results handed from the arithmetic unit
    typedef struct packed {
        logic [15:0] current;
        logic [23:0] power;
        logic        done;
    } pml_calc_t;

endpackage

// [src/pml_calc.sv]
// Purpose: Current and power derivation from shunt, bus and calibration
// Assumes: start is a one-cycle pulse on pclk
// Notes:   Results register one cycle after start
module pml_calc (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               start,
    input  wire logic [15:0]        shunt,
    input  wire logic [15:0]        bus,
    input  wire logic [14:0]        cal,
    output pml_pkg::pml_calc_t      res
);
    import pml_pkg::*;

    pml_calc_t   q;
    pml_calc_t   next_q;
    logic [31:0] prod;
    logic [31:0] cur_wide;
    logic [15:0] cur;
    logic [15:0] cur_mag;
    logic [31:0] pwr_wide;

    // Saturate a wide signed value to 16 bits
    function automatic logic [15:0] sat16(input logic [31:0] v);
        if ($signed(v) > 32'sh0000_7FFF) begin
            sat16 = 16'h7FFF;
        end else if ($signed(v) < -32'sh0000_8000) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // Multiply and scale; shunt is signed, calibration unsigned
    always_comb begin
        prod     = 32'($signed(shunt) * $signed({1'b0, cal}));
        cur_wide = 32'($signed(prod) >>> PML_CUR_SHIFT);
        cur      = (cal == 15'h0000) ? 16'h0000 : sat16(cur_wide);
        cur_mag  = cur[15] ? 16'(-cur) : cur;
        // Power LSB is 0.2 of the current LSB at 3.125 mV bus steps
        pwr_wide = (32'(cur_mag) * 32'(bus)) >> PML_PWR_SHIFT;
        next_q   = q;
        next_q.done = start;
        if (start) begin
            next_q.current = cur;
            next_q.power   = (pwr_wide[31:24] != 8'h00) ? 24'hFF_FFFF : pwr_wide[23:0];
        end
    end

    // Results held in flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign res = q;

endmodule

// [src/pml_top.sv]
// Purpose: Result, limit compare and alert logic of a shunt power monitor
// Assumes: presetn is the supply power-up reset; front end sends
//          conversion words framed on its own link clock
// Notes:   Registers over APB, one word each, zero wait states
// Function
// - Power-up: wide shunt range, continuous conversion
// - Configuration registers reload reset values at power-up
// - Zero calibration forces current and power zero
// - Alert selectable: limit violation or conversion ready
// - Shunt result compared to 5 uV limit
// - Bus result compared to 3.125 mV limit
// - Power limit compared with upper 16 bits
// - Limit registers restore defaults at power-up
// - Results two's complement; bus never negative
// - Power LSB is 0.2 current LSB
// - Large faults may alert within quarter conversion
// - Marginal faults alert within 0.5 to 1.5 conversions
//
// The register addresses and the APB slave port were decided locally.
module pml_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              link_clk,
    input  wire logic              link_frame,
    input  wire pml_pkg::pml_sample_t link_sample,
    output logic                   range_narrow,
    output logic [2:0]             conv_enable,
    output logic                   alert,
    output logic                   irq
);
    import pml_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // All state of the block except the current and power results, held in u_calc
    typedef struct packed {
        logic                       clk_s1;
        logic                       clk_s2;
        logic                       clk_d;
        logic                       frm_s1;
        logic                       frm_s2;
        pml_sample_t                smp_s1;
        pml_sample_t                smp_s2;
        logic [2:0]                 cfg;
        logic [2:0]                 adc_en;
        logic [1:0]                 adc_avg;
        logic [14:0]                cal;
        logic [15:0]                shunt_lim;
        logic [15:0]                bus_lim;
        logic [15:0]                pwr_lim;
        logic [15:0]                shunt_res;
        logic [15:0]                bus_res;
        logic [15:0]                temp_res;
        logic [2:0][PML_ACC_W-1:0]  acc;
        logic [2:0][5:0]            cnt;
        logic [3:0]                 sts;
        logic [3:0]                 mask;
        logic                       calc_go;
        logic [31:0]                rdata;
        logic                       err;
    } pml_state_t;

    pml_state_t             q;
    pml_state_t             next_q;
    pml_calc_t              calc;
    logic                   take;
    logic                   last;
    logic                   do_cmp;
    logic [1:0]             ch;
    logic [2:0]             shift;
    logic [PML_ACC_W-1:0]   sum;
    logic [15:0]            avg;
    logic [15:0]            cmp_val;
    logic [15:0]            shunt_5uv;
    logic [3:0]             set;
    logic [3:0]             clr;
    logic                   wr;
    logic                   setup;
    logic                   mapped;
    logic [31:0]            rd;

    ////////////////////////////////////////////////////////////////////////////
    // Averaging depth is 4^avg: 1, 4, 16 or 64 conversions
    function automatic logic [2:0] avg_shift(input logic [1:0] sel);
        avg_shift = {sel, 1'b0};
    endfunction

    function automatic logic [5:0] avg_last(input logic [1:0] sel);
        avg_last = 6'((7'h01 << avg_shift(sel)) - 7'h01);
    endfunction

    // Negative bus codes are clamped since the bus reading is positive only
    function automatic logic [15:0] bus_clamp(input logic [15:0] v);
        bus_clamp = v[15] ? 16'h0000 : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic unit for current and power
    pml_calc u_calc (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (q.calc_go),
        .shunt   (q.shunt_res),
        .bus     (q.bus_res),
        .cal     (q.cal),
        .res     (calc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux; unmapped addresses answer zero with an error
    always_comb begin
        rd     = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == PML_OFS_CONFIG) begin
            rd = 32'(q.cfg);
        end else if (paddr == PML_OFS_ADC_CONFIG) begin
            rd = 32'({q.adc_avg, q.adc_en});
        end else if (paddr == PML_OFS_SHUNT_CAL) begin
            rd = 32'(q.cal);
        end else if (paddr == PML_OFS_SHUNT_RES) begin
            rd = 32'(q.shunt_res);
        end else if (paddr == PML_OFS_BUS_RES) begin
            rd = 32'(q.bus_res);
        end else if (paddr == PML_OFS_TEMP_RES) begin
            rd = 32'(q.temp_res);
        end else if (paddr == PML_OFS_CURRENT) begin
            rd = 32'(calc.current);
        end else if (paddr == PML_OFS_POWER) begin
            rd = 32'(calc.power);
        end else if (paddr == PML_OFS_SHUNT_LIM) begin
            rd = 32'(q.shunt_lim);
        end else if (paddr == PML_OFS_BUS_LIM) begin
            rd = 32'(q.bus_lim);
        end else if (paddr == PML_OFS_POWER_LIM) begin
            rd = 32'(q.pwr_lim);
        end else if (paddr == PML_OFS_IRQ_STS) begin
            rd = 32'(q.sts);
        end else if (paddr == PML_OFS_IRQ_MASK) begin
            rd = 32'(q.mask);
        end else begin
            mapped = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_q = q;
        set    = 4'h0;
        clr    = 4'h0;
        wr     = psel & penable & pwrite;
        setup  = psel & ~penable;

        // Two-flop synchronisers for everything from the link side
        next_q.clk_s1 = link_clk;
        next_q.clk_s2 = q.clk_s1;
        next_q.clk_d  = q.clk_s2;
        next_q.frm_s1 = link_frame;
        next_q.frm_s2 = q.frm_s1;
        next_q.smp_s1 = link_sample;
        next_q.smp_s2 = q.smp_s1;

        // A word is taken on the link clock's rising edge inside a frame
        ch    = q.smp_s2.chan;
        take  = q.clk_s2 & ~q.clk_d & q.frm_s2 & (ch != 2'h3);
        take  = take && q.adc_en[ch];
        shift = avg_shift(q.adc_avg);
        sum   = PML_ACC_W'(q.acc[ch[1] ? 2 : ch[0]]) + {{6{q.smp_s2.data[15]}}, q.smp_s2.data};
        last  = (q.cnt[ch[1] ? 2 : ch[0]] == avg_last(q.adc_avg));
        avg   = 16'($signed(sum) >>> shift);

        // Accumulate; publish the averaged result on the last of the group
        next_q.calc_go = 1'b0;
        if (take) begin
            if (last) begin
                next_q.acc[ch[1] ? 2 : ch[0]] = '0;
                next_q.cnt[ch[1] ? 2 : ch[0]] = 6'h00;
                set[PML_STS_CNVRDY] = 1'b1;
                if (ch == PML_CH_SHUNT) begin
                    next_q.shunt_res = avg;
                    next_q.calc_go   = 1'b1;
                end else if (ch == PML_CH_BUS) begin
                    next_q.bus_res   = bus_clamp(avg);
                    next_q.calc_go   = 1'b1;
                end else begin
                    next_q.temp_res  = avg;
                end
            end else begin
                next_q.acc[ch[1] ? 2 : ch[0]] = sum;
                next_q.cnt[ch[1] ? 2 : ch[0]] = q.cnt[ch[1] ? 2 : ch[0]] + 6'h01;
            end
        end

        // Shunt and bus limits checked on every raw word, or only on averaged results
        do_cmp  = take & (~q.cfg[PML_CFG_AVGAL_BIT] | last);
        cmp_val = q.cfg[PML_CFG_AVGAL_BIT] ? avg : q.smp_s2.data;
        // Narrow-range codes are rescaled to the 5 uV limit unit
        shunt_5uv = q.cfg[PML_CFG_RANGE_BIT] ?
                    16'($signed(cmp_val) >>> PML_NARROW_SHR) : cmp_val;
        // Flagged on the very result that crosses: the latency is one
        // conversion plus the crossing, so no extra filtering is added
        if (do_cmp && ch == PML_CH_SHUNT &&
            $signed(shunt_5uv) > $signed(q.shunt_lim)) begin
            set[PML_STS_SHUNT] = 1'b1;
        end
        if (do_cmp && ch == PML_CH_BUS && bus_clamp(cmp_val) > q.bus_lim) begin
            set[PML_STS_BUS] = 1'b1;
        end
        if (calc.done && calc.power[23:PML_PLIM_SHIFT] > q.pwr_lim) begin
            set[PML_STS_POWER] = 1'b1;
        end

        // APB writes take effect in the access cycle
        if (wr) begin
            if (paddr == PML_OFS_CONFIG) begin
                next_q.cfg = pwdata[2:0];
            end else if (paddr == PML_OFS_ADC_CONFIG) begin
                next_q.adc_en  = pwdata[2:0];
                next_q.adc_avg = pwdata[PML_ADC_AVG_LSB +: 2];
            end else if (paddr == PML_OFS_SHUNT_CAL) begin
                next_q.cal = pwdata[14:0];
            end else if (paddr == PML_OFS_SHUNT_LIM) begin
                next_q.shunt_lim = pwdata[15:0];
            end else if (paddr == PML_OFS_BUS_LIM) begin
                next_q.bus_lim = pwdata[15:0];
            end else if (paddr == PML_OFS_POWER_LIM) begin
                next_q.pwr_lim = pwdata[15:0];
            end else if (paddr == PML_OFS_IRQ_STS) begin
                clr = pwdata[3:0];
            end else if (paddr == PML_OFS_IRQ_MASK) begin
                next_q.mask = pwdata[3:0];
            end
        end
        // A new event beats a clear in the same cycle
        next_q.sts = (q.sts & ~clr) | set;

        // Read data and error are captured in the setup cycle
        if (setup) begin
            next_q.rdata = rd;
            next_q.err   = ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; power-up reset restores every setting and limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.cfg       <= PML_RST_CONFIG;
            q.adc_en    <= PML_RST_ADC_EN;
            q.adc_avg   <= PML_RST_ADC_AVG;
            q.cal       <= PML_RST_CAL;
            q.shunt_lim <= PML_RST_SLIM;
            q.bus_lim   <= PML_RST_BLIM;
            q.pwr_lim   <= PML_RST_PLIM;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata       = q.rdata;
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & q.err;
    assign range_narrow = q.cfg[PML_CFG_RANGE_BIT];
    assign conv_enable  = q.adc_en;
    // Alert pin shows either ready or any limit flag
    assign alert        = q.cfg[PML_CFG_CNVAL_BIT] ? q.sts[PML_STS_CNVRDY] :
                          |q.sts[PML_STS_POWER:PML_STS_SHUNT];
    assign irq          = |(q.sts & q.mask);

endmodule

// [verification/pml_properties.sv]
// Purpose: Port-level checks of the limit and alert block
// Assumes: One clock domain on pclk, reset presetn
// Notes:   Attached to pml_top by the bind at the foot
module pml_properties (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       link_frame,
    input wire logic       range_narrow,
    input wire logic [2:0] conv_enable,
    input wire logic       alert,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import pml_pkg::*;

    ////////////////////////////////////////
    // Completed writes, one per register that may move an output
    wire logic wr    = psel && penable && pwrite;
    wire logic w_cfg = wr && paddr == PML_OFS_CONFIG;
    wire logic w_adc = wr && paddr == PML_OFS_ADC_CONFIG;
    wire logic w_sts = wr && paddr == PML_OFS_IRQ_STS;
    wire logic w_msk = wr && paddr == PML_OFS_IRQ_MASK;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_reset_vals;
        $rose(presetn) |-> !range_narrow && conv_enable == 3'h7 && !alert && !irq;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong value after reset");
    property p_range_hold;
        !$stable(range_narrow) |-> $past(w_cfg);
    endproperty
    a_range_hold: assert property (p_range_hold) else $error("range moved alone");
    property p_enable_hold;
        !$stable(conv_enable) |-> $past(w_adc);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enables moved alone");
    // Alert is sticky: only a clear or a new selection drops it
    property p_alert_fall;
        $fell(alert) |-> $past(w_sts || w_cfg);
    endproperty
    a_alert_fall: assert property (p_alert_fall) else $error("alert dropped alone");
    // A new alert follows a framed word within a few cycles
    property p_alert_rise;
        $rose(alert) |-> $past(w_cfg) || $past(link_frame, 6);
    endproperty
    a_alert_rise: assert property (p_alert_rise) else $error("alert without cause");
    property p_irq_fall;
        $fell(irq) |-> $past(w_sts || w_msk);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    property p_irq_rise;
        $rose(irq) |-> $past(w_msk) || $past(link_frame, 6);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
    property p_slverr;
        pslverr || (psel && penable && paddr > PML_OFS_IRQ_MASK)
            |-> psel && penable && pslverr && pready;
    endproperty
    a_slverr: assert property (p_slverr) else $error("error response wrong");

    c_alert: cover property ($rose(alert));
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
endmodule

bind pml_top pml_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .link_frame(link_frame), .range_narrow(range_narrow),
    .conv_enable(conv_enable), .alert(alert), .irq(irq)
);

// [verification/pml_fe_model.sv]
// Purpose: Front-end model sending conversion words on the link
// Assumes: One word per frame, 200 ns link clock
// Notes:   Link clock stands still between frames
module pml_fe_model (
    output logic                 link_clk,
    output logic                 link_frame,
    output pml_pkg::pml_sample_t link_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    import pml_pkg::*;

    // Idle link at start
    initial begin
        link_clk = 1'b0;
        link_frame = 1'b0;
        link_sample = '0;
    end

    // One conversion result; offset keeps link edges off pclk edges
    task automatic send(input logic [1:0] ch, input logic [15:0] val);
        #7;
        link_sample = {ch, val};
        link_frame = 1'b1;
        #100 link_clk = 1'b1;
        #100 link_clk = 1'b0;
        #50 link_frame = 1'b0;
        link_sample = ~link_sample; // Stale word must not look valid
        #50;
    endtask
endmodule

// [verification/pml_top_test.sv]
// Purpose: Self-checking bench of the limit and alert block
// Assumes: Front-end model feeds words; APB master in tasks
// Notes:   Expected results worked out by hand from the scaling
module pml_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pml_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        link_clk;
    logic        link_frame;
    pml_sample_t link_sample;
    logic        range_narrow;
    logic [2:0]  conv_enable;
    logic        alert;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          checks;

    pml_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
        .link_frame(link_frame), .link_sample(link_sample),
        .range_narrow(range_narrow), .conv_enable(conv_enable),
        .alert(alert), .irq(irq)
    );
    pml_fe_model fe (.link_clk(link_clk), .link_frame(link_frame), .link_sample(link_sample));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////
    // Verdict, reached from the tests or from the watchdog
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // APB transfer; the request holds until pready is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    // One word, then time for results and flags to settle
    task automatic cv(input logic [1:0] c, input logic [15:0] v);
        fe.send(c, v);
        repeat (4) @(posedge pclk);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic chk_defaults();
        logic [7:0]  ofs [7] = '{PML_OFS_CONFIG, PML_OFS_ADC_CONFIG, PML_OFS_SHUNT_CAL,
            PML_OFS_SHUNT_LIM, PML_OFS_BUS_LIM, PML_OFS_POWER_LIM, PML_OFS_IRQ_MASK};
        logic [31:0] want [7] = '{32'h0, 32'h7, 32'h0, 32'h7FFF, 32'h7FFF, 32'hFFFF, 32'h0};
        for (int i = 0; i < 7; i++) begin
            rc(ofs[i], want[i]);
        end
        chk("narrow", 32'h0, {31'h0, range_narrow});
        chk("enables", 32'h7, {29'h0, conv_enable});
    endtask

    // Hang guard, far beyond the dozen or so microseconds needed
    initial begin
        #200000;
        fails++;
        give_verdict();
    end

    ////////////////////////////////////////
    // Test sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        fails = 0;
        checks = 0;
        do_reset();
        chk_defaults();
        wr(PML_OFS_CONFIG, 32'h1);
        wr(PML_OFS_ADC_CONFIG, 32'h3);
        wr(PML_OFS_SHUNT_LIM, 32'h1234);
        // Temperature disabled: its word must be ignored
        cv(PML_CH_TEMP, 16'h1234);
        rc(PML_OFS_TEMP_RES, 32'h0);
        @(posedge pclk);
        chk("narrow", 32'h1, {31'h0, range_narrow});
        chk("enables", 32'h3, {29'h0, conv_enable});
        do_reset();
        chk_defaults();
        cv(PML_CH_BUS, 16'h3C00);
        cv(PML_CH_SHUNT, 16'h03E8);
        rc(PML_OFS_CURRENT, 32'h0);
        rc(PML_OFS_POWER, 32'h0);
        wr(PML_OFS_SHUNT_CAL, 32'h0800);
        cv(PML_CH_SHUNT, 16'h03E8);
        rc(PML_OFS_CURRENT, 32'h03E8);
        rc(PML_OFS_POWER, 32'h0003_A980);
        cv(PML_CH_SHUNT, 16'hB410);
        rc(PML_OFS_SHUNT_RES, 32'hB410);
        rc(PML_OFS_CURRENT, 32'hB410);
        rc(PML_OFS_POWER, 32'h0047_3100);
        cv(PML_CH_TEMP, 16'hFF38);
        rc(PML_OFS_TEMP_RES, 32'hFF38);
        cv(PML_CH_BUS, 16'h8000);
        rc(PML_OFS_BUS_RES, 32'h0);
        // Limits: equal is no fault, one code above is
        cv(PML_CH_BUS, 16'h3C00);
        wr(PML_OFS_SHUNT_LIM, 32'h03E8);
        wr(PML_OFS_IRQ_STS, 32'hF);
        cv(PML_CH_SHUNT, 16'h03E8);
        rc(PML_OFS_IRQ_STS, 32'h8);
        cv(PML_CH_SHUNT, 16'h03E9);
        rc(PML_OFS_IRQ_STS, 32'h9);
        chk("alert", 32'h1, {31'h0, alert});
        wr(PML_OFS_IRQ_STS, 32'hF);
        @(posedge pclk);
        chk("alert", 32'h0, {31'h0, alert});
        wr(PML_OFS_BUS_LIM, 32'h4100);
        cv(PML_CH_BUS, 16'h4101);
        rc(PML_OFS_IRQ_STS, 32'hA);
        wr(PML_OFS_BUS_LIM, 32'h7FFF);
        wr(PML_OFS_POWER_LIM, 32'h03AA);
        wr(PML_OFS_IRQ_STS, 32'hF);
        cv(PML_CH_BUS, 16'h3C00);
        rc(PML_OFS_IRQ_STS, 32'h8);
        wr(PML_OFS_POWER_LIM, 32'h03A9);
        wr(PML_OFS_IRQ_STS, 32'hF);
        cv(PML_CH_BUS, 16'h3C00);
        rc(PML_OFS_IRQ_STS, 32'hC);
        // Alert on conversion ready; irq masked, unmasked, cleared
        wr(PML_OFS_CONFIG, 32'h4);
        wr(PML_OFS_IRQ_STS, 32'hF);
        cv(PML_CH_TEMP, 16'h00C8);
        chk("alert", 32'h1, {31'h0, alert});
        chk("irq", 32'h0, {31'h0, irq});
        wr(PML_OFS_IRQ_MASK, 32'h8);
        @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(PML_OFS_IRQ_STS, 32'h8);
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        chk("alert", 32'h0, {31'h0, alert});
        // Refused accesses
        wr(PML_OFS_SHUNT_RES, 32'h1234);
        rc(PML_OFS_SHUNT_RES, 32'h03E9);
        rc(8'h40, 32'h0);
        chk("error", 32'h1, {31'h0, err});
        // Raw against averaged limit checking, averaging of four
        wr(PML_OFS_ADC_CONFIG, 32'hF);
        wr(PML_OFS_CONFIG, 32'h2);
        wr(PML_OFS_IRQ_STS, 32'hF);
        cv(PML_CH_SHUNT, 16'h07D0);
        rc(PML_OFS_IRQ_STS, 32'h0);
        wr(PML_OFS_CONFIG, 32'h0);
        cv(PML_CH_SHUNT, 16'h07D0);
        rc(PML_OFS_IRQ_STS, 32'h1);
        // Narrow range: raw codes scaled down by four before the compare
        wr(PML_OFS_CONFIG, 32'h1);
        wr(PML_OFS_IRQ_STS, 32'hF);
        cv(PML_CH_SHUNT, 16'h0FA3);
        rc(PML_OFS_IRQ_STS, 32'h0);
        // Fourth word closes the group of four: average, ready and power flag
        cv(PML_CH_SHUNT, 16'h0FA4);
        rc(PML_OFS_IRQ_STS, 32'hD);
        rc(PML_OFS_SHUNT_RES, 32'h0BB9);
        give_verdict();
    end
endmodule
